// >>> aop_pkg.sv
// constants, field layout and link carrier for the output phase and pattern registers
// assumes a single 100 MHz clock that stands in for the multiplied serial clock
package aop_pkg;

  // register offsets on the serial control port
  localparam logic [12:0] AOP_ADDR_FORMAT = 13'h0014;
  localparam logic [12:0] AOP_ADDR_DRIVE = 13'h0015;
  localparam logic [12:0] AOP_ADDR_PHASE = 13'h0016;
  localparam logic [12:0] AOP_ADDR_PAT_LO = 13'h0019;
  localparam logic [12:0] AOP_ADDR_PAT_HI = 13'h001A;

  // reset values
  localparam logic [7:0] AOP_RST_FORMAT = 8'h00;
  localparam logic [7:0] AOP_RST_DRIVE = 8'h00;
  localparam logic [7:0] AOP_RST_PHASE = 8'h03;
  localparam logic [7:0] AOP_RST_PAT_LO = 8'h00;
  localparam logic [7:0] AOP_RST_PAT_HI = 8'h00;

  // field positions
  localparam int AOP_PHASE_LSB = 0;
  localparam int AOP_FMT_LSB = 0;
  localparam int AOP_INVERT_BIT = 2;
  localparam int AOP_LOWPWR_BIT = 6;
  localparam logic [1:0] AOP_FMT_TWOS = 2'h1;

  // serial port framing
  localparam logic [3:0] AOP_INSTR_LAST = 4'hF;
  localparam logic [3:0] AOP_DATA_LAST = 4'h7;
  localparam int AOP_READ_BIT = 15;

  // output clock timing: one tick is 60 degrees of the output data clock
  localparam logic [2:0] AOP_TICKS_PER_DCLK = 3'h6;
  localparam logic [2:0] AOP_TICKS_PER_HALF = 3'h3;
  localparam logic [3:0] AOP_PHASE_TOP = 4'hB;

  typedef enum logic [1:0] {SPI_IDLE, SPI_INSTR, SPI_DATA, SPI_DONE} aop_spi_state_type;

  // serial output link towards the receiver
  typedef struct packed {
    logic data;
    logic dclk;
    logic fclk;
  } aop_link_type;

endpackage

// >>> aop_regs.sv
// output phase select, user pattern one and format registers behind a serial control port,
// with the serialiser whose output data clock phase they steer
// assumes spi pins come from outside the clock domain; adc words come from logic on mclk_i
//
// How it works
// [R1] the low nibble of the clock phase register picks which divider phase drives the data clock out
// [R2] every step of the phase code moves the data clock out by sixty degrees, code zero aligned to data
// [R3] after reset the phase code is three, the 180 degree point, and the register reads 0x03
// [R4] software only writes phase codes zero to eleven, codes past eleven being outside that range
// [R5] pattern one low byte is a reset-to-zero register holding pattern bits 7 to 0
// [R6] pattern one high byte is a reset-to-zero register holding pattern bits 15 to 8
// [R7] a test pattern sent instead of converted data goes through the current output format
// [R8] moving the output clock phase never moves the internal data latching
`timescale 1ns/1ps
module aop_regs #(
  parameter int DATA_WIDTH = 12
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic spi_csb_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdio_i,
  output logic spi_sdio_o,
  output logic spi_sdio_oe_o,
  input wire logic [DATA_WIDTH-1:0] adc_data_i,
  input wire logic pattern_sel_i,
  output aop_pkg::aop_link_type link_o,
  output logic [7:0] output_drive_config_o,
  output logic lvds_low_power_o
);
  import aop_pkg::*;

  // elaboration check: two bits go out per data clock period
  if (DATA_WIDTH < 2 || DATA_WIDTH > 16 || (DATA_WIDTH % 2) != 0)
  begin : g_bad_width
    $error("DATA_WIDTH must be even and between 2 and 16");
  end

  function automatic logic hit(input logic [12:0] addr, input logic [12:0] offset);
    hit = (addr == offset);
  endfunction

  logic [2:0] s1_q, s2_q, s3_q, pin_q;
  logic [2:0] agree, pin_d;
  logic csb_n, sclk_rise, sclk_fall, sdio_in;

  // three-stage pin capture; bit 2 csb, bit 1 sclk, bit 0 sdio
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      s1_q <= 3'h4;
      s2_q <= 3'h4;
      s3_q <= 3'h4;
      pin_q <= 3'h4;
    end
    else
    begin
      s1_q <= {spi_csb_n_i, spi_sclk_i, spi_sdio_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  // a change counts once the second and third stages agree; glitches of one cycle are dropped
  assign agree = ~(s2_q ^ s3_q);
  assign pin_d = (agree & s2_q) | (~agree & pin_q);
  assign csb_n = pin_d[2];
  assign sclk_rise = pin_d[1] & ~pin_q[1];
  assign sclk_fall = ~pin_d[1] & pin_q[1];
  assign sdio_in = pin_d[0];

  aop_spi_state_type state_q;
  logic [3:0] cnt_q;
  logic [15:0] instr_q;
  logic [7:0] shift_q;
  logic sdio_q, sdio_oe_q;
  logic [7:0] format_q, drive_q, phase_q, pat_lo_q, pat_hi_q;
  logic [12:0] instr_addr;
  logic is_read, wr_stb;
  logic [7:0] wr_data, rd_data;

  // address taken from the instruction as its last bit arrives
  assign instr_addr = {instr_q[11:0], sdio_in};
  assign is_read = instr_q[AOP_READ_BIT];
  assign wr_data = {shift_q[6:0], sdio_in};
  assign wr_stb = (state_q == SPI_DATA) && !is_read && sclk_rise && (cnt_q == AOP_DATA_LAST);

  // read mux; unmapped addresses read zero
  assign rd_data = hit(instr_addr, AOP_ADDR_FORMAT) ? format_q :
                   hit(instr_addr, AOP_ADDR_DRIVE) ? drive_q :
                   hit(instr_addr, AOP_ADDR_PHASE) ? phase_q :
                   hit(instr_addr, AOP_ADDR_PAT_LO) ? pat_lo_q :
                   hit(instr_addr, AOP_ADDR_PAT_HI) ? pat_hi_q : 8'h00;

  // serial port: 16 instruction bits msb first, then one data byte; sampled on sclk rise
  always_ff @(posedge mclk_i)
  begin
    if (srst_i || csb_n)
    begin
      state_q <= SPI_IDLE;
      cnt_q <= 4'h0;
      instr_q <= 16'h0000;
      shift_q <= 8'h00;
      sdio_q <= 1'b0;
      sdio_oe_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        SPI_IDLE:
        begin
          state_q <= SPI_INSTR;
          cnt_q <= 4'h0;
        end
        SPI_INSTR:
        begin
          if (sclk_rise)
          begin
            instr_q <= {instr_q[14:0], sdio_in};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == AOP_INSTR_LAST)
            begin
              state_q <= SPI_DATA;
              cnt_q <= 4'h0;
              shift_q <= instr_q[14] ? rd_data : 8'h00;
            end
          end
        end
        SPI_DATA:
        begin
          // read data leaves on falling edges so the host samples it on rising ones
          if (is_read && sclk_fall)
          begin
            sdio_q <= shift_q[7];
            sdio_oe_q <= 1'b1;
            shift_q <= {shift_q[6:0], 1'b0};
          end
          if (!is_read && sclk_rise)
          begin
            shift_q <= wr_data;
          end
          if (sclk_rise)
          begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == AOP_DATA_LAST)
            begin
              state_q <= SPI_DONE;
            end
          end
        end
        SPI_DONE:
        begin
          // release the line after the last bit; extra clocks are ignored
          if (sclk_fall)
          begin
            sdio_oe_q <= 1'b0;
          end
        end
      endcase
    end
  end

  assign spi_sdio_o = sdio_q;
  assign spi_sdio_oe_o = sdio_oe_q;

  // [R3] [R5] [R6] register file, defaults on reset
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      format_q <= AOP_RST_FORMAT;
      drive_q <= AOP_RST_DRIVE;
      phase_q <= AOP_RST_PHASE;
      pat_lo_q <= AOP_RST_PAT_LO;
      pat_hi_q <= AOP_RST_PAT_HI;
    end
    else if (wr_stb)
    begin
      if (hit(instr_q[12:0], AOP_ADDR_FORMAT)) format_q <= wr_data;
      if (hit(instr_q[12:0], AOP_ADDR_DRIVE)) drive_q <= wr_data;
      // [R1] phase nibble kept, upper bits read zero
      if (hit(instr_q[12:0], AOP_ADDR_PHASE)) phase_q <= {4'h0, wr_data[AOP_PHASE_LSB+:4]};
      if (hit(instr_q[12:0], AOP_ADDR_PAT_LO)) pat_lo_q <= wr_data;
      if (hit(instr_q[12:0], AOP_ADDR_PAT_HI)) pat_hi_q <= wr_data;
    end
  end

  assign output_drive_config_o = drive_q;
  assign lvds_low_power_o = format_q[AOP_LOWPWR_BIT];

  logic [2:0] tick_q, tick_d;
  logic [3:0] bit_q;
  logic [DATA_WIDTH-1:0] sh_q, src_word, fmt_word;
  logic [15:0] pattern;
  logic advance, last_bit;
  logic [3:0] code_c;
  logic [2:0] ph6, rel;
  logic dclk_q, fclk_q;

  // [R7] pattern takes the top bits and passes the same format stage as data
  assign pattern = {pat_hi_q, pat_lo_q};
  assign src_word = pattern_sel_i ? pattern[15-:DATA_WIDTH] : adc_data_i;
  assign fmt_word = (format_q[AOP_FMT_LSB+:2] == AOP_FMT_TWOS) ?
                    {~src_word[DATA_WIDTH-1], src_word[DATA_WIDTH-2:0]} ^ {DATA_WIDTH{format_q[AOP_INVERT_BIT]}} :
                    src_word ^ {DATA_WIDTH{format_q[AOP_INVERT_BIT]}};

  // [R8] data timing follows the free tick counter only, never the phase code
  assign tick_d = (tick_q == AOP_TICKS_PER_DCLK - 3'h1) ? 3'h0 : tick_q + 3'h1;
  assign advance = (tick_d == 3'h0) || (tick_d == AOP_TICKS_PER_HALF);
  assign last_bit = (bit_q == 4'(DATA_WIDTH - 1));

  // [R4] codes past eleven are outside use; clamp so the divider never runs off
  assign code_c = (phase_q[3:0] > AOP_PHASE_TOP) ? AOP_PHASE_TOP : phase_q[3:0];
  // [R2] sixty degrees per step, 360 degrees wraps to the same edge
  assign ph6 = (code_c >= 4'h6) ? 3'(code_c - 4'h6) : code_c[2:0];
  assign rel = (tick_d >= ph6) ? 3'(tick_d - ph6) : 3'(tick_d + AOP_TICKS_PER_DCLK - ph6);

  // serialiser: two bits per data clock period, msb first, frame clock high for the first half
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      tick_q <= 3'h0;
      // start on the last bit so the first advance loads a whole frame, not a short one
      bit_q <= 4'(DATA_WIDTH - 1);
      sh_q <= '0;
      dclk_q <= 1'b0;
      fclk_q <= 1'b0;
    end
    else
    begin
      tick_q <= tick_d;
      // [R1] selected divider phase drives the clock out
      dclk_q <= (rel < AOP_TICKS_PER_HALF);
      if (advance)
      begin
        bit_q <= last_bit ? 4'h0 : bit_q + 4'h1;
        sh_q <= last_bit ? fmt_word : {sh_q[DATA_WIDTH-2:0], 1'b0};
        fclk_q <= last_bit || (bit_q < 4'(DATA_WIDTH / 2 - 1));
      end
    end
  end

  // one driver for the whole link struct
  assign link_o = '{data: sh_q[DATA_WIDTH-1], dclk: dclk_q, fclk: fclk_q};

endmodule

// >>> aop_regs_sva.sv
// timing checks on the serial output link and the control port of aop_regs
// assumes one clock domain on mclk_i with srst_i as its reset
`timescale 1ns/1ps
module aop_regs_sva import aop_pkg::*; #(
  parameter int DATA_WIDTH = 12
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic spi_csb_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdio_i,
  input wire logic spi_sdio_o,
  input wire logic spi_sdio_oe_o,
  input wire logic [DATA_WIDTH-1:0] adc_data_i,
  input wire logic pattern_sel_i,
  input wire aop_pkg::aop_link_type link_o,
  input wire logic [7:0] output_drive_config_o,
  input wire logic lvds_low_power_o
);
  localparam int HALF = DATA_WIDTH * 3 / 2;
  logic [3:0] idle_q;
  // idle count: a phase write may stretch one clock half
  always_ff @(posedge mclk_i)
  begin
    if (srst_i || !spi_csb_n_i)
      idle_q <= 4'h0;
    else if (idle_q != 4'hF)
      idle_q <= idle_q + 4'h1;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence s_clk_hold;
    $stable(link_o.dclk) [*2];
  endsequence
  sequence s_dat_hold;
    $stable(link_o.data) [*2];
  endsequence
  AST_DCLK_HALF: assert property (idle_q == 4'hF && $changed(link_o.dclk) |=> s_clk_hold ##1 $changed(link_o.dclk))
    else $error("data clock half period wrong");
  AST_DCLK_NEAR: assert property (idle_q == 4'hF && $changed(link_o.data) |-> ##[0:2] $changed(link_o.dclk))
    else $error("data clock edge not within a bit");
  AST_RST_OUT: assert property ($fell(srst_i) |-> link_o == '0 && output_drive_config_o == 8'h00 && !spi_sdio_oe_o)
    else $error("outputs not cleared by reset");
  AST_DATA_BIT: assert property ($changed(link_o.data) |=> s_dat_hold)
    else $error("data bit shorter than three cycles");
  AST_FCLK_HALF: assert property ($rose(link_o.fclk) |-> ##HALF $fell(link_o.fclk))
    else $error("frame clock high time wrong");
  AST_OE_IDLE: assert property (idle_q == 4'hF |-> !spi_sdio_oe_o)
    else $error("sdio driven while deselected");
  AST_FMT_HOLD: assert property (idle_q == 4'hF |-> $stable(lvds_low_power_o) && $stable(output_drive_config_o))
    else $error("config output moved without a write");
endmodule
bind aop_regs aop_regs_sva #(.DATA_WIDTH(DATA_WIDTH)) i_sva (.mclk_i(mclk_i), .srst_i(srst_i),
  .spi_csb_n_i(spi_csb_n_i), .spi_sclk_i(spi_sclk_i), .spi_sdio_i(spi_sdio_i), .spi_sdio_o(spi_sdio_o),
  .spi_sdio_oe_o(spi_sdio_oe_o), .adc_data_i(adc_data_i), .pattern_sel_i(pattern_sel_i), .link_o(link_o),
  .output_drive_config_o(output_drive_config_o), .lvds_low_power_o(lvds_low_power_o));

// >>> aop_link_rx.sv
// receiver model: rebuilds each frame word and measures clock-to-data lag
// assumes frame clock rises with the first bit of a frame
`timescale 1ns/1ps
module aop_link_rx import aop_pkg::*; #(
  parameter int W = 12
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire aop_pkg::aop_link_type link_i,
  output logic [W-1:0] word_o,
  output logic [2:0] lag_o
);
  logic d_q, k_q, f_q;
  logic [1:0] q_q;
  logic [2:0] cnt_q;
  logic [W-1:0] sh_q;
  wire logic dchg = link_i.data != d_q;
  wire logic kchg = link_i.dclk != k_q;
  wire logic frise = link_i.fclk && !f_q;
  // lag needs a toggling data stream, else the count runs on
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      {d_q, k_q, f_q, q_q, cnt_q, sh_q, word_o, lag_o} <= '0;
    end
    else
    begin
      {d_q, k_q, f_q} <= {link_i.data, link_i.dclk, link_i.fclk};
      cnt_q <= dchg ? 3'h1 : cnt_q + 3'h1;
      if (kchg)
        lag_o <= dchg ? 3'h0 : cnt_q;
      q_q <= frise ? 2'h0 : (q_q == 2'h2 ? 2'h0 : q_q + 2'h1);
      if (frise)
        word_o <= sh_q;
      if (q_q == 2'h1)
        sh_q <= {sh_q[W-2:0], link_i.data};
    end
  end
endmodule

// >>> adc_output_phase_pattern_regs_tb_top.sv
// self-checking bench for aop_regs: serial port host plus link receiver
// assumes 100 MHz mclk_i and a 12-bit converted word
`timescale 1ns/1ps
module adc_output_phase_pattern_regs_tb_top;
  import aop_pkg::*;
  typedef struct {logic [7:0] hi, lo, fm; logic [11:0] w;} aop_row_type;
  aop_row_type rows [5] = '{'{8'hAB, 8'hCD, 8'h00, 12'hABC}, '{8'h12, 8'h30, 8'h01, 12'h923},
    '{8'hF0, 8'h0F, 8'h04, 12'h0FF}, '{8'h80, 8'h00, 8'h05, 12'hFFF}, '{8'h5A, 8'h5A, 8'h40, 12'h5A5}};
  logic mclk_i = 0, srst = 1, csb = 1, sclk = 1, sdio = 0, psel = 0, sdo, oe, lp;
  logic [11:0] adc = 12'hAAA, word;
  logic [7:0] drv, r;
  logic [2:0] lag;
  aop_link_type link;
  int fails = 0, tests_run = 0;
  wire logic sdio_w = oe ? sdo : sdio;
  always #5 mclk_i = ~mclk_i;
  aop_regs #(.DATA_WIDTH(12)) i_dut (.mclk_i(mclk_i), .srst_i(srst), .spi_csb_n_i(csb), .spi_sclk_i(sclk),
    .spi_sdio_i(sdio_w), .spi_sdio_o(sdo), .spi_sdio_oe_o(oe), .adc_data_i(adc), .pattern_sel_i(psel),
    .link_o(link), .output_drive_config_o(drv), .lvds_low_power_o(lp));
  aop_link_rx #(.W(12)) i_rx (.mclk_i(mclk_i), .srst_i(srst), .link_i(link), .word_o(word), .lag_o(lag));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one framed transfer; fewer than 24 bits aborts it
  task automatic sp(input logic [15:0] ins, input logic [7:0] wd, input int n);
    logic [23:0] f;
    f = {ins, wd};
    csb <= 1'b0;
    cyc(6);
    for (int i = 0; i < n; i++)
    begin
      sdio <= f[23-i];
      sclk <= 1'b0;
      cyc(6);
      sclk <= 1'b1;
      cyc(6);
      if (i > 15)
        r = {r[6:0], sdo};
    end
    csb <= 1'b1;
    cyc(8);
  endtask
  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    sp({3'h4, a}, 8'h00, 24);
    chk("readback", {8'h00, r}, {8'h00, e});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge mclk_i);
    fails++;
    summarize;
  end
  initial
  begin
    cyc(16);
    srst <= 1'b0;
    cyc(4);
    rdc(AOP_ADDR_FORMAT, 8'h00);
    rdc(AOP_ADDR_DRIVE, 8'h00);
    rdc(AOP_ADDR_PHASE, 8'h03);
    rdc(AOP_ADDR_PAT_LO, 8'h00);
    rdc(AOP_ADDR_PAT_HI, 8'h00);
    rdc(13'h0017, 8'h00);
    $display("reset values done");
    psel <= 1'b1;
    foreach (rows[i])
    begin
      sp({3'h0, AOP_ADDR_PAT_HI}, rows[i].hi, 24);
      sp({3'h0, AOP_ADDR_PAT_LO}, rows[i].lo, 24);
      sp({3'h0, AOP_ADDR_FORMAT}, rows[i].fm, 24);
      cyc(120);
      chk("pattern word", {4'h0, word}, {4'h0, rows[i].w});
      chk("low power", {15'h0, lp}, {15'h0, rows[i].fm[6]});
    end
    sp({3'h0, AOP_ADDR_FORMAT}, 8'h00, 24);
    psel <= 1'b0;
    cyc(120);
    chk("adc word", {4'h0, word}, 16'h0AAA);
    $display("pattern rows done");
    // every listed phase code, then one beyond the range
    for (int c = 0; c < 12; c++)
    begin
      sp({3'h0, AOP_ADDR_PHASE}, 8'(c), 24);
      cyc(40);
      chk("lag", {13'h0, lag}, 16'(c % 3));
      chk("adc word at phase", {4'h0, word}, 16'h0AAA);
      rdc(AOP_ADDR_PHASE, 8'(c));
    end
    sp({3'h0, AOP_ADDR_PHASE}, 8'hFE, 24);
    cyc(40);
    chk("lag", {13'h0, lag}, 16'h0002);
    rdc(AOP_ADDR_PHASE, 8'h0E);
    $display("phase codes done");
    sp({3'h0, AOP_ADDR_DRIVE}, 8'h30, 24);
    sp({3'h0, AOP_ADDR_DRIVE}, 8'h0C, 20);
    chk("drive", {8'h00, drv}, 16'h0030);
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    cyc(4);
    chk("drive", {8'h00, drv}, 16'h0000);
    rdc(AOP_ADDR_PHASE, 8'h03);
    $display("abort and reset done");
    summarize;
  end
endmodule
